/* File: core/stc_map.vh */
// Register map, field positions and reset values of the 16-bit timer/counter.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef STC_MAP_VH
`define STC_MAP_VH

// ============================================================
// Register indices; byte address is four times the index
`define STC_IDX_COUNT_LOW 6'h0E
`define STC_IDX_COUNT_HIGH 6'h0F
`define STC_IDX_CONTROL 6'h10
`define STC_IDX_STATUS 6'h11

// ============================================================
// Control register fields
`define STC_CTL_ON 0
`define STC_CTL_SRC 1
`define STC_CTL_SYNC_BYPASS 2
`define STC_CTL_OSC_EN 3
`define STC_CTL_PS_LO 4
`define STC_CTL_PS_HI 5
`define STC_CTL_RESET 6'h00

// ============================================================
// Status register fields
`define STC_STS_FLAG 0
`define STC_STS_IRQ_EN 1

// ============================================================
// Counter limits and bus answers
`define STC_COUNT_MAX 16'hFFFF
`define STC_COUNT_ZERO 16'h0000
`define STC_RESP_OKAY 2'h0
`define STC_RESP_SLVERR 2'h2

`endif

/* File: core/stc_timer.v */
// 16-bit timer/counter with 1:1..1:8 prescaler and an AXI4-Lite slave.
// Assumes one 250 MHz clock, external count pins asynchronous to it, and
// trigger and sleep inputs produced by logic on the same clock.
`timescale 1ns/1ps
`include "stc_map.vh"
`default_nettype none

module stc_timer (
    input wire clk,
    input wire rst_n,
    // AXI4-Lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Count pins, asynchronous
    input wire osc_input_pin,
    input wire ext_count_input_pin,
    // Oscillator inverter power
    output wire osc_amp_enable,
    // Core sleep state
    input wire sleep,
    // Special event triggers of compare units a and b
    input wire compare_unit_a_trigger,
    input wire compare_unit_b_trigger,
    // Count to compare units and its validity as time base
    output wire [15:0] count_value,
    output wire time_base_valid,
    // Overflow interrupt and wake request
    output wire overflow_irq
);

    // ========================================================
    // Registers
    reg [5:0] counter_control; // Control bits 5..0
    reg [15:0] count; // The counter itself
    reg overflow_flag; // Sticky overflow flag
    reg overflow_irq_enable; // Overflow interrupt mask

    wire counter_on = counter_control[`STC_CTL_ON];
    wire clock_source_select = counter_control[`STC_CTL_SRC];
    wire sync_bypass = counter_control[`STC_CTL_SYNC_BYPASS];
    wire osc_enable = counter_control[`STC_CTL_OSC_EN];
    wire [1:0] prescale_select =
        counter_control[`STC_CTL_PS_HI:`STC_CTL_PS_LO];

    // Async mode: external source with synchroniser bypassed
    wire async_mode = clock_source_select & sync_bypass;

    // ========================================================
    // Bus slave: write channels
    reg aw_full; // Write address held
    reg w_full; // Write data held
    reg [5:0] wr_idx; // Held word index
    reg [7:0] wr_byte; // Held low data byte
    reg wr_lane; // Held strobe of lane 0

    assign s_axi_awready = ~aw_full & ~s_axi_bvalid;
    assign s_axi_wready = ~w_full & ~s_axi_bvalid;

    // Write commits once both halves are in and no response pending
    wire do_wr = aw_full & w_full & ~s_axi_bvalid;
    wire wr_ok = do_wr & wr_lane;
    wire wr_low = wr_ok & (wr_idx == `STC_IDX_COUNT_LOW);
    wire wr_high = wr_ok & (wr_idx == `STC_IDX_COUNT_HIGH);
    wire wr_ctl = wr_ok & (wr_idx == `STC_IDX_CONTROL);
    wire wr_sts = wr_ok & (wr_idx == `STC_IDX_STATUS);
    wire wr_count = wr_low | wr_high;
    wire wr_mapped = (wr_idx == `STC_IDX_COUNT_LOW) |
        (wr_idx == `STC_IDX_COUNT_HIGH) |
        (wr_idx == `STC_IDX_CONTROL) | (wr_idx == `STC_IDX_STATUS);

    // Address and data taken in either order
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            wr_idx <= 6'h00;
            wr_byte <= 8'h00;
            wr_lane <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `STC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_full <= 1'b1;
                wr_idx <= s_axi_awaddr[7:2];
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_full <= 1'b1;
                wr_byte <= s_axi_wdata[7:0];
                wr_lane <= s_axi_wstrb[0];
            end
            if (do_wr) begin
                // Response one cycle after both halves held
                aw_full <= 1'b0;
                w_full <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? `STC_RESP_OKAY :
                    `STC_RESP_SLVERR;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ========================================================
    // Bus slave: read channel
    assign s_axi_arready = ~s_axi_rvalid;
    wire [5:0] rd_idx = s_axi_araddr[7:2];

    // Counter bytes come from the clocked count; low and high are separate reads, so a running count can tear
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `STC_RESP_OKAY;
        end else if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `STC_RESP_OKAY;
            case (rd_idx)
                `STC_IDX_COUNT_LOW: begin
                    s_axi_rdata <= {24'h000000, count[7:0]};
                end
                `STC_IDX_COUNT_HIGH: begin
                    s_axi_rdata <= {24'h000000, count[15:8]};
                end
                `STC_IDX_CONTROL: begin
                    s_axi_rdata <= {26'h0, counter_control};
                end
                `STC_IDX_STATUS: begin
                    s_axi_rdata <= {30'h0, overflow_irq_enable,
                        overflow_flag};
                end
                default: begin
                    // Unmapped word reads zero with an error
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `STC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ========================================================
    // Control and status registers
    // Only power-on/brown-out reset reaches rst_n, so control clears here
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            counter_control <= `STC_CTL_RESET;
            overflow_irq_enable <= 1'b0;
        end else begin
            if (wr_ctl) begin
                counter_control <= wr_byte[5:0];
            end
            if (wr_sts) begin
                overflow_irq_enable <= wr_byte[`STC_STS_IRQ_EN];
            end
        end
    end

    // Oscillator inverter follows the enable bit, sleep or not
    assign osc_amp_enable = osc_enable;

    // ========================================================
    // Pin synchronisers, two flops each before any logic
    reg osc_s1;
    reg osc_s2;
    reg cki_s1;
    reg cki_s2;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            cki_s1 <= 1'b0;
            cki_s2 <= 1'b0;
        end else begin
            osc_s1 <= osc_input_pin;
            osc_s2 <= osc_s1;
            cki_s1 <= ext_count_input_pin;
            cki_s2 <= cki_s1;
        end
    end

    // Pin choice by oscillator enable
    wire ext_level = osc_enable ? osc_s2 : cki_s2;

    // ========================================================
    // External edge detection and first-falling-edge arming
    reg ext_prev; // Previous external level
    reg ext_armed; // Falling edge seen since external selected
    wire ext_rise = ext_level & ~ext_prev;
    wire ext_fall = ~ext_level & ext_prev;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_prev <= 1'b0;
            ext_armed <= 1'b0;
        end else begin
            ext_prev <= ext_level;
            if (!clock_source_select) begin
                ext_armed <= 1'b0;
            end else if (ext_fall) begin
                ext_armed <= 1'b1;
            end
        end
    end

    // ========================================================
    // Prescaler
    // Source ticks: every clock outside sleep in timer mode, armed rising edges else
    reg [2:0] pre_cnt; // Prescaler count, not visible to software
    wire int_tick = ~clock_source_select & ~sleep;
    wire ext_tick = clock_source_select & ext_armed & ext_rise;
    wire src_tick = counter_on & (int_tick | ext_tick);

    // Divider mask: 000, 001, 011, 111 for 1:1..1:8
    reg [2:0] pre_mask;
    always @* begin
        case (prescale_select)
            2'h0: pre_mask = 3'h0;
            2'h1: pre_mask = 3'h1;
            2'h2: pre_mask = 3'h3;
            default: pre_mask = 3'h7;
        endcase
    end

    // Keeps counting external edges in sleep; cleared by count writes
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt <= 3'h0;
        end else if (wr_count) begin
            pre_cnt <= 3'h0;
        end else if (src_tick) begin
            pre_cnt <= pre_cnt + 3'h1;
        end
    end

    // Timer mode: divided tick taken directly, internal clock is in step
    wire int_div_hit = int_tick & src_tick &
        ((pre_cnt & pre_mask) == pre_mask);

    // External prescaler output level; edges rise once per division
    reg ps_out;
    always @* begin
        case (prescale_select)
            2'h0: ps_out = ext_armed & ext_level;
            2'h1: ps_out = pre_cnt[0];
            2'h2: ps_out = pre_cnt[1];
            default: ps_out = pre_cnt[2];
        endcase
    end

    // ========================================================
    // Prescaler output synchroniser and direct path
    reg ps_s1; // First flop, read only by ps_s2
    reg ps_s2;
    reg ps_s3; // Edge history of synchronised output
    reg ps_prev; // Edge history of direct output
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ps_s1 <= 1'b0;
            ps_s2 <= 1'b0;
            ps_s3 <= 1'b0;
            ps_prev <= 1'b0;
        end else begin
            ps_s1 <= ps_out;
            ps_s2 <= ps_s1;
            ps_s3 <= ps_s2;
            ps_prev <= ps_out;
        end
    end

    // Synchroniser is off in sleep, so sync mode stalls there
    wire sync_en = ps_s2 & ~ps_s3 & ~sleep;
    // Direct path keeps running through sleep
    wire async_en = ps_out & ~ps_prev;

    // Count enable by mode; a stopped counter holds
    wire count_en = counter_on & (clock_source_select ?
        (sync_bypass ? async_en : sync_en) : int_div_hit);

    // ========================================================
    // Counter, special event clear, overflow
    wire trigger = compare_unit_a_trigger | compare_unit_b_trigger;
    // Clear only in timer or synchronised counter mode
    wire sev_clear = trigger & ~async_mode;
    wire wrap = count_en & (count == `STC_COUNT_MAX);

    // Priority: software write, then special event, then increment
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= `STC_COUNT_ZERO;
        end else if (wr_count) begin
            // Byte writes while counting may race; stop the counter first
            if (wr_low) begin
                count[7:0] <= wr_byte;
            end else begin
                count[15:8] <= wr_byte;
            end
        end else if (sev_clear) begin
            count <= `STC_COUNT_ZERO;
        end else if (count_en) begin
            count <= count + 16'h0001;
        end
    end

    // Sticky flag; hardware set wins over a software clear
    wire flag_set = wrap & ~wr_count & ~sev_clear;
    wire flag_clr = wr_sts & wr_byte[`STC_STS_FLAG];
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overflow_flag <= 1'b0;
        end else begin
            overflow_flag <= flag_set | (overflow_flag & ~flag_clr);
        end
    end

    // Masked overflow doubles as wake request in async mode
    assign overflow_irq = overflow_flag & overflow_irq_enable;

    // ========================================================
    // Compare unit interface
    assign count_value = count;
    assign time_base_valid = counter_on & ~async_mode;

endmodule // stc_timer

`default_nettype wire

/* File: verification/stc_ext_src.sv */
// External count source: clock pin or crystal on the oscillator pin.
// Assumes the bench calls pulses(); both pins rest low between bursts.
`timescale 1ns/1ps
`default_nettype none
module stc_ext_src (
    output logic osc_input_pin,
    output logic ext_count_input_pin
);
    // ============================================================
    // Idle low, so the first burst after external selection starts with a rise that is not counted
    initial begin
        osc_input_pin = 1'b0;
        ext_count_input_pin = 1'b0;
    end
    // Odd offset keeps edges unrelated to the core clock
    task automatic pulses(input bit on_osc, input int n, input int hp);
        repeat (n) begin
            #(hp + 1.3);
            if (on_osc) osc_input_pin = 1'b1;
            else ext_count_input_pin = 1'b1;
            #(hp);
            osc_input_pin = 1'b0;
            ext_count_input_pin = 1'b0;
        end
    endtask
endmodule // stc_ext_src
`default_nettype wire

/* File: verification/stc_timer_properties.sv */
// Checker for the timer/counter top: bus handshakes and count behaviour.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module stc_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic compare_unit_a_trigger,
    input wire logic compare_unit_b_trigger,
    input wire logic [15:0] count_value,
    input wire logic time_base_valid,
    input wire logic osc_amp_enable,
    input wire logic overflow_irq
);
    // ============================================================
    // Bus answers
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bresp dropped");
    property p_aw_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_aw_block: assert property (p_aw_block) else $error("aw open");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("rdata dropped");
    property p_r_ans;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_ans: assert property (p_r_ans) else $error("no read answer");
    // ============================================================
    // Count behaviour; a write commit is the edge where bvalid rises
    property p_sev_clr;
        (compare_unit_a_trigger || compare_unit_b_trigger) && time_base_valid
        ##1 !$rose(s_axi_bvalid) |-> count_value == 16'h0000;
    endproperty
    a_sev_clr: assert property (p_sev_clr) else $error("no clear");
    property p_step;
        $changed(count_value) && !$rose(s_axi_bvalid) |->
        count_value == $past(count_value) + 16'h0001 ||
        count_value == 16'h0000;
    endproperty
    a_step: assert property (p_step) else $error("bad count step");
    property p_irq;
        $rose(overflow_irq) && !$rose(s_axi_bvalid) |-> count_value < 16'h0004;
    endproperty
    a_irq: assert property (p_irq) else $error("irq without wrap");
    // Control outputs only move on a register commit
    property p_ctl;
        !$rose(s_axi_bvalid) |-> $stable({osc_amp_enable, time_base_valid});
    endproperty
    a_ctl: assert property (p_ctl) else $error("control moved");
endmodule // stc_props
bind stc_timer stc_props u_props (.clk(clk), .rst_n(rst_n),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .compare_unit_a_trigger(compare_unit_a_trigger),
    .compare_unit_b_trigger(compare_unit_b_trigger),
    .count_value(count_value), .time_base_valid(time_base_valid),
    .osc_amp_enable(osc_amp_enable), .overflow_irq(overflow_irq));
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the timer/counter over AXI4-Lite.
// Assumes the bound checker and the external source model.
`timescale 1ns/1ps
`default_nettype none
`include "stc_map.vh"
module tb;
    logic clk = 1'b0, rst_n = 1'b0, sleep = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, trig_a = 1'b0, trig_b = 1'b0;
    logic [31:0] wdata = 32'h0;
    wire awready, wready, bvalid, arready, rvalid, osc_en, tbv, irq;
    wire osc_pin, ext_pin;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [15:0] count;
    int bad_count = 0, compares = 0, cyc = 0, n;
    logic [31:0] rq[$]; // Expected read data
    logic [1:0] bq[$]; // Expected write answers
    logic [1:0] rrq[$]; // Expected read answers
    localparam logic [7:0] A_LO = {`STC_IDX_COUNT_LOW, 2'b00};
    localparam logic [7:0] A_HI = {`STC_IDX_COUNT_HIGH, 2'b00};
    localparam logic [7:0] A_CT = {`STC_IDX_CONTROL, 2'b00};
    localparam logic [7:0] A_ST = {`STC_IDX_STATUS, 2'b00};
    localparam logic [1:0] OK = `STC_RESP_OKAY, ER = `STC_RESP_SLVERR;
    stc_timer uut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .osc_input_pin(osc_pin),
        .ext_count_input_pin(ext_pin), .osc_amp_enable(osc_en),
        .sleep(sleep), .compare_unit_a_trigger(trig_a),
        .compare_unit_b_trigger(trig_b), .count_value(count),
        .time_base_valid(tbv), .overflow_irq(irq));
    stc_ext_src src (.osc_input_pin(osc_pin), .ext_count_input_pin(ext_pin));
    // ============================================================
    // Clock, reset and hang guard
    initial forever #2 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Scoreboard: oldest note against each answer
    always @(posedge clk) begin
        if (rvalid && rready) begin
            chk(rdata, rq.pop_front());
            chk({30'h0, rresp}, {30'h0, rrq.pop_front()});
        end
        if (bvalid && bready) begin
            chk({30'h0, bresp}, {30'h0, bq.pop_front()});
        end
    end
    // ============================================================
    // Bus tasks; each channel held until its own ready
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] r);
        bq.push_back(r);
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (awvalid || wvalid);
        do @(posedge clk); while (!bvalid);
        bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        // Unmapped words answer with an error code
        rrq.push_back((a == A_LO || a == A_HI || a == A_CT ||
            a == A_ST) ? OK : ER);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 0;
        do @(posedge clk); while (!rvalid);
        rready <= 0;
    endtask
    task automatic gap(input logic [15:0] c, output int k);
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (count === c && k < 100);
    endtask
    task automatic pulse_trig(input bit b);
        @(posedge clk);
        if (b) begin
            trig_b <= 1'b1;
        end else begin
            trig_a <= 1'b1;
        end
        @(posedge clk);
        trig_a <= 1'b0;
        trig_b <= 1'b0;
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ============================================================
    // Main sequence
    initial begin
        logic [7:0] lo, hi;
        int k;
        void'($urandom(32'hD1443F35));
        repeat (8) @(posedge clk);
        rst_n <= 1;
        rd(A_CT, 32'h0);
        wr(A_CT, 8'hF0, OK);
        rd(A_CT, 32'h30);
        wr(8'h00, 8'h12, ER);
        rd(8'h00, 32'h0);
        wr(A_CT, 8'h00, OK);
        lo = 8'($urandom);
        hi = 8'($urandom);
        wr(A_LO, lo, OK);
        wr(A_HI, hi, OK);
        rd(A_LO, {24'h0, lo});
        rd(A_HI, {24'h0, hi});
        $display("test regs done");
        for (int ps = 0; ps < 4; ps++) begin
            wr(A_LO, 8'h00, OK);
            wr(A_CT, {2'b00, ps[1:0], 4'h1}, OK);
            chk({31'h0, tbv}, 32'h1);
            gap(count, k);
            gap(count, k);
            chk(k, 1 << ps);
            wr(A_CT, 8'h00, OK);
            lo = count[7:0];
            repeat (20) @(posedge clk);
            rd(A_LO, {24'h0, lo});
        end
        $display("test prescale done");
        wr(A_LO, 8'h00, OK);
        wr(A_CT, 8'h0B, OK);
        chk({31'h0, osc_en}, 32'h1);
        n = 3 + $urandom % 5;
        src.pulses(0, n, 40);
        src.pulses(1, n, 40);
        repeat (20) @(posedge clk);
        rd(A_LO, n - 1);
        wr(A_CT, 8'h0F, OK);
        chk({31'h0, tbv}, 32'h0);
        sleep <= 1;
        src.pulses(1, n, 40);
        repeat (20) @(posedge clk);
        rd(A_LO, 2 * n - 1);
        chk({31'h0, osc_en}, 32'h1);
        pulse_trig(0);
        rd(A_LO, 2 * n - 1);
        wr(A_CT, 8'h0B, OK);
        src.pulses(1, n, 40);
        repeat (20) @(posedge clk);
        rd(A_LO, 2 * n - 1);
        sleep <= 0;
        $display("test external done");
        wr(A_CT, 8'h00, OK);
        chk({31'h0, osc_en}, 32'h0);
        wr(A_LO, 8'hF0, OK);
        wr(A_HI, 8'hFF, OK);
        wr(A_ST, 8'h02, OK);
        wr(A_CT, 8'h01, OK);
        repeat (40) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        rd(A_ST, 32'h3);
        // Enable bit shares the word, so keep it set while clearing
        wr(A_ST, 8'h03, OK);
        rd(A_ST, 32'h2);
        pulse_trig(0);
        pulse_trig(1);
        // Clear lands on the edge that sampled the trigger
        @(posedge clk);
        chk({16'h0, count}, 32'h0);
        rd(A_ST, 32'h2);
        chk({31'h0, irq}, 32'h0);
        // Trigger held high exactly at the count write commit edge
        wr(A_CT, 8'h00, OK);
        fork
            wr(A_LO, 8'h5A, OK);
            begin
                repeat (2) @(posedge clk);
                trig_a <= 1'b1;
                @(posedge clk);
                trig_a <= 1'b0;
            end
        join
        rd(A_LO, 32'h5A);
        $display("test overflow done");
        close_out();
    end
endmodule // tb
`default_nettype wire
